/* src/mbf_pkg.sv */
package mbf_pkg;
	localparam logic [7:0] FN_READ = 8'h03;
	localparam logic [7:0] FN_WRITE = 8'h06;
	localparam logic [7:0] FN_DIAG = 8'h08;
	localparam logic [7:0] FN_PASS = 8'h41;
	localparam logic [7:0] FN_ERR_BIT = 8'h80;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_DATA = 8'h03;
	localparam logic [7:0] EXC_LINK = 8'h0b;
	localparam logic [15:0] SUB_ECHO = 16'h0000;
	localparam logic [15:0] SUB_RESTART = 16'h0001;
	localparam logic [15:0] SUB_LISTEN = 16'h0004;
	localparam logic [15:0] LISTEN_DATA = 16'h0000;
	localparam logic [7:0] RESTART_KEEP = 8'h00;
	localparam logic [7:0] RESTART_CLEAR = 8'hff;
	localparam logic [15:0] REG_TIMEOUT = 16'h0000;
	localparam logic [15:0] REG_WR_MAX = 16'h0005;
	localparam logic [15:0] REG_RD_MAX = 16'h0017;
	localparam logic [15:0] RD_COUNT_ONE = 16'h0001;
	localparam logic [7:0] RD_BYTES = 8'h02;
	localparam logic [7:0] TIMEOUT_RST = 8'h02;
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [7:0] ASC_ZERO = 8'h30;
	localparam logic [7:0] ASC_ALPHA = 8'h37;
	localparam int FRAME_MAX = 10;
	localparam logic [3:0] FRAME_LEN = 4'd10;
	localparam logic [3:0] CMD_POS = 4'd2;
	localparam logic [3:0] MIN_FRAME = 4'd2;
	localparam logic [3:0] REQ_LEN = 4'd6;
	localparam logic [3:0] ERR_LEN = 4'd3;
	localparam logic [3:0] RD_RSP_LEN = 4'd5;
	localparam logic [3:0] PASS_MIN = 4'd1;
	localparam logic [3:0] PASS_MAX = 4'd8;
	localparam logic [3:0] REG_CMD_LEN = 4'd4;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic last;
	} mbf_byte_type;

	typedef struct packed {
		logic req;
		logic offline;
		logic is_reg;
		logic wr;
		logic [7:0] timeout;
		logic [3:0] len;
		logic [63:0] cmd;
	} mbf_dn_req_type;

	typedef struct packed {
		logic done;
		logic err;
		logic [2:0] len;
		logic [31:0] data;
	} mbf_dn_rsp_type;

	function automatic logic [15:0] mbf_crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] v;
		v = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			v = v[0] ? ((v >> 1) ^ CRC_POLY) : (v >> 1);
		end
		return v;
	endfunction

	function automatic logic [7:0] mbf_hex(input logic [3:0] n);
		return (n < 4'ha) ? (ASC_ZERO + {4'h0, n}) : (ASC_ALPHA + {4'h0, n});
	endfunction
endpackage

/* src/mbf_handler.sv */
`timescale 1ns/100ps
module mbf_handler (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ascii,
	input wire mbf_pkg::mbf_byte_type i_rx,
	input wire logic i_tx_ready,
	input wire mbf_pkg::mbf_dn_rsp_type i_dn,
	input wire logic [3:0] i_dn_exp_len,
	output mbf_pkg::mbf_byte_type o_tx,
	output mbf_pkg::mbf_dn_req_type o_dn,
	output logic o_busy,
	output logic o_listen
);
	import mbf_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RX = 3'b000,
		ST_EXEC = 3'b001,
		ST_DN = 3'b010,
		ST_SEND = 3'b011,
		ST_CHK = 3'b100
	} mbf_state_type;

	mbf_state_type state_q, state_d;
	logic [7:0] buf_q [FRAME_MAX];
	logic [7:0] buf_d [FRAME_MAX];
	logic [3:0] cnt_q, cnt_d, rlen_q, rlen_d, idx_q, idx_d;
	logic ovf_q, ovf_d, listen_q, listen_d, silent_q, silent_d, chk_q, chk_d;
	logic busy_q, busy_d;
	logic [7:0] tmo_q, tmo_d, lrc_q, lrc_d;
	logic [15:0] crc_q, crc_d;
	mbf_byte_type tx_q, tx_d;
	mbf_dn_req_type dn_q, dn_d;
	logic [7:0] fn, exc, lrc_neg;
	logic [15:0] adr, dat;
	logic [3:0] plen;
	logic [2:0] slot;
	logic err;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		buf_d = buf_q;
		cnt_d = cnt_q;
		rlen_d = rlen_q;
		idx_d = idx_q;
		ovf_d = ovf_q;
		listen_d = listen_q;
		silent_d = silent_q;
		chk_d = chk_q;
		tmo_d = tmo_q;
		lrc_d = lrc_q;
		crc_d = crc_q;
		tx_d = tx_q;
		dn_d = dn_q;
		fn = buf_q[1];
		adr = {buf_q[2], buf_q[3]};
		dat = {buf_q[4], buf_q[5]};
		plen = cnt_q - CMD_POS;
		slot = 3'(cnt_q - CMD_POS);
		err = 1'b0;
		exc = EXC_DATA;
		lrc_neg = 8'h00 - lrc_q;
		dn_d.offline = listen_d;
		dn_d.timeout = tmo_d;
		unique case (state_q)
			ST_RX: begin
				if (i_rx.valid) begin
					if (cnt_q < FRAME_LEN) begin
						buf_d[cnt_q] = i_rx.data;
						cnt_d = cnt_q + 4'd1;
					end else begin
						ovf_d = 1'b1;
					end
					if (cnt_q >= CMD_POS && cnt_q < FRAME_LEN) begin
						dn_d.cmd[{slot, 3'b000} +: 8] = i_rx.data;
					end
					if (i_rx.last) begin
						state_d = ST_EXEC;
					end
				end
			end
			ST_EXEC: begin
				cnt_d = 4'd0;
				ovf_d = 1'b0;
				idx_d = 4'd0;
				crc_d = CRC_INIT;
				lrc_d = 8'h00;
				chk_d = 1'b0;
				rlen_d = cnt_q;
				state_d = ST_SEND;
				silent_d = (buf_q[0] == BCAST_ADDR);
				if (cnt_q < MIN_FRAME) begin
					state_d = ST_RX;
				end else if (listen_q) begin
					state_d = ST_RX;
					if (fn == FN_DIAG && cnt_q == REQ_LEN && adr == SUB_RESTART &&
						(buf_q[4] == RESTART_KEEP || buf_q[4] == RESTART_CLEAR)) begin
						listen_d = 1'b0;
					end
				end else begin
					unique case (fn)
						FN_READ: begin
							if (cnt_q != REQ_LEN || adr > REG_RD_MAX || dat != RD_COUNT_ONE) begin
								err = 1'b1;
							end else if (adr == REG_TIMEOUT) begin
								buf_d[2] = RD_BYTES;
								buf_d[3] = 8'h00;
								buf_d[4] = tmo_q;
								rlen_d = RD_RSP_LEN;
							end else begin
								dn_d.req = 1'b1;
								dn_d.is_reg = 1'b1;
								dn_d.wr = 1'b0;
								dn_d.len = REG_CMD_LEN;
								state_d = ST_DN;
							end
						end
						FN_WRITE: begin
							if (cnt_q != REQ_LEN || adr > REG_WR_MAX ||
								(adr == REG_TIMEOUT && buf_q[4] != 8'h00)) begin
								err = 1'b1;
							end else if (adr == REG_TIMEOUT) begin
								tmo_d = buf_q[5];
							end else begin
								dn_d.req = 1'b1;
								dn_d.is_reg = 1'b1;
								dn_d.wr = 1'b1;
								dn_d.len = REG_CMD_LEN;
								state_d = ST_DN;
							end
						end
						FN_DIAG: begin
							if (cnt_q != REQ_LEN) begin
								err = 1'b1;
							end else begin
								unique case (adr)
									SUB_ECHO: rlen_d = cnt_q;
									SUB_RESTART: begin
										err = !(buf_q[4] == RESTART_KEEP ||
											buf_q[4] == RESTART_CLEAR);
									end
									SUB_LISTEN: begin
										if (dat != LISTEN_DATA) begin
											err = 1'b1;
										end else begin
											listen_d = 1'b1;
											state_d = ST_RX;
										end
									end
									default: err = 1'b1;
								endcase
							end
						end
						FN_PASS: begin
							if (ovf_q || plen < PASS_MIN || plen > PASS_MAX ||
								plen != i_dn_exp_len) begin
								err = 1'b1;
							end else begin
								dn_d.req = 1'b1;
								dn_d.is_reg = 1'b0;
								dn_d.wr = 1'b0;
								dn_d.len = plen;
								state_d = ST_DN;
							end
						end
						default: begin
							err = 1'b1;
							exc = EXC_FUNC;
						end
					endcase
				end
				if (err) begin
					buf_d[1] = fn | FN_ERR_BIT;
					buf_d[2] = exc;
					rlen_d = ERR_LEN;
					state_d = ST_SEND;
				end
				dn_d.offline = listen_d;
				dn_d.timeout = tmo_d;
			end
			ST_DN: begin
				if (i_dn.done) begin
					dn_d.req = 1'b0;
					state_d = ST_SEND;
					if (i_dn.err) begin
						buf_d[1] = fn | FN_ERR_BIT;
						buf_d[2] = EXC_LINK;
						rlen_d = ERR_LEN;
					end else if (dn_q.is_reg && !dn_q.wr) begin
						buf_d[2] = RD_BYTES;
						buf_d[3] = i_dn.data[15:8];
						buf_d[4] = i_dn.data[7:0];
						rlen_d = RD_RSP_LEN;
					end else if (!dn_q.is_reg) begin
						for (int i = 0; i < 4; i++) begin
							if (i < int'(i_dn.len)) begin
								buf_d[2 + i] = i_dn.data[8 * i +: 8];
							end
						end
						rlen_d = CMD_POS + {1'b0, i_dn.len};
					end
				end
			end
			ST_SEND: begin
				if (silent_q) begin
					state_d = ST_RX;
				end else if (!tx_q.valid || i_tx_ready) begin
					tx_d.valid = 1'b1;
					tx_d.last = 1'b0;
					if (idx_q < rlen_q) begin
						tx_d.data = buf_q[idx_q];
						crc_d = mbf_crc_byte(crc_q, buf_q[idx_q]);
						lrc_d = lrc_q + buf_q[idx_q];
						idx_d = idx_q + 4'd1;
					end else begin
						tx_d.data = i_ascii ? mbf_hex(lrc_neg[7:4]) : crc_q[7:0];
						state_d = ST_CHK;
					end
				end
			end
			ST_CHK: begin
				if (i_tx_ready) begin
					if (!chk_q) begin
						tx_d.data = i_ascii ? mbf_hex(lrc_neg[3:0]) : crc_q[15:8];
						tx_d.last = 1'b1;
						chk_d = 1'b1;
					end else begin
						tx_d.valid = 1'b0;
						tx_d.last = 1'b0;
						state_d = ST_RX;
					end
				end
			end
			default: state_d = ST_RX;
		endcase
		busy_d = (state_d != ST_RX);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= ST_RX;
			for (int i = 0; i < FRAME_MAX; i++) begin
				buf_q[i] <= 8'h00;
			end
			cnt_q <= 4'd0;
			rlen_q <= 4'd0;
			idx_q <= 4'd0;
			ovf_q <= 1'b0;
			listen_q <= 1'b0;
			silent_q <= 1'b0;
			chk_q <= 1'b0;
			busy_q <= 1'b0;
			tmo_q <= TIMEOUT_RST;
			lrc_q <= 8'h00;
			crc_q <= CRC_INIT;
			tx_q <= '0;
			dn_q <= '{timeout: TIMEOUT_RST, default: '0};
		end else begin
			state_q <= state_d;
			buf_q <= buf_d;
			cnt_q <= cnt_d;
			rlen_q <= rlen_d;
			idx_q <= idx_d;
			ovf_q <= ovf_d;
			listen_q <= listen_d;
			silent_q <= silent_d;
			chk_q <= chk_d;
			busy_q <= busy_d;
			tmo_q <= tmo_d;
			lrc_q <= lrc_d;
			crc_q <= crc_d;
			tx_q <= tx_d;
			dn_q <= dn_d;
		end
	end

	assign o_tx = tx_q;
	assign o_dn = dn_q;
	assign o_busy = busy_q;
	assign o_listen = listen_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// Frames shorter than two bytes carry a stale function byte, so they are kept out.
	sequence exec_write_bad;
		state_q == ST_EXEC && !listen_q && cnt_q >= MIN_FRAME && fn == FN_WRITE &&
			adr > REG_WR_MAX;
	endsequence
	sequence chk_pair;
		tx_q.valid && state_q == ST_CHK && !chk_q && i_tx_ready ##1 tx_q.last;
	endsequence

	offline_track_a: assert property (listen_q |-> o_dn.offline)
		else $error("port online in listen");
	tmo_read_a: assert property (state_q == ST_EXEC && !listen_q && fn == FN_READ
		&& cnt_q == REQ_LEN && adr == REG_TIMEOUT && dat == RD_COUNT_ONE
		|=> buf_q[3] == 8'h00 && buf_q[4] == tmo_q)
		else $error("timeout readback wrong");
	tmo_hold_a: assert property ($changed(tmo_q)
		|-> $past(state_q) == ST_EXEC && $past(fn) == FN_WRITE)
		else $error("timeout changed without write");
	wr_range_a: assert property (exec_write_bad
		|=> buf_q[1][7] && buf_q[2] == EXC_DATA && rlen_q == ERR_LEN)
		else $error("bad write not refused");
	listen_enter_a: assert property (state_q == ST_EXEC && !listen_q && fn == FN_DIAG
		&& cnt_q == REQ_LEN && adr == SUB_LISTEN && dat == LISTEN_DATA
		|=> listen_q && state_q == ST_RX)
		else $error("listen entry failed");
	listen_quiet_a: assert property (state_q == ST_EXEC && listen_q
		|=> state_q == ST_RX && !tx_q.valid)
		else $error("answer in listen mode");
	bcast_quiet_a: assert property (silent_q && state_q == ST_SEND
		|=> !tx_q.valid && state_q == ST_RX)
		else $error("broadcast answered");
	crc_order_a: assert property (chk_pair
		|-> i_ascii || tx_q.data == $past(crc_q[15:8]))
		else $error("check byte order wrong");
	link_err_a: assert property (state_q == ST_DN && i_dn.done && i_dn.err
		|=> buf_q[2] == EXC_LINK)
		else $error("link error not reported");
	pass_len_a: assert property (state_q == ST_EXEC && !listen_q && fn == FN_PASS
		&& cnt_q >= MIN_FRAME && plen != i_dn_exp_len
		|=> !o_dn.req && buf_q[2] == EXC_DATA)
		else $error("bad pass count forwarded");
endmodule // mbf_handler

/* testbench/mbf_master_model.sv */
`timescale 1ns/100ps
// ------
// Bus master model
// ------
module mbf_master_model (
	input wire logic i_clk,
	input wire logic i_busy,
	input wire mbf_pkg::mbf_byte_type i_tx,
	output mbf_pkg::mbf_byte_type o_rx,
	output logic o_tx_ready
);
	import mbf_pkg::*;
	int ph = 0;
	initial begin
		o_rx = '0;
		o_tx_ready = 1'b1;
	end
	// Stalls every third cycle so that a held response byte is exercised.
	always @(posedge i_clk) begin
		ph <= ph + 1;
		o_tx_ready <= (ph % 3) != 0;
	end
	task automatic xfer(input int f[$], output logic [7:0] g[$]);
		int n;
		g = {};
		foreach (f[k]) begin
			@(posedge i_clk);
			o_rx <= '{valid: 1'b1, data: f[k][7:0], last: k == f.size() - 1};
		end
		@(posedge i_clk);
		o_rx <= '0;
		n = 0;
		while (n < 300) begin
			@(posedge i_clk);
			n++;
			if (i_tx.valid && o_tx_ready) begin
				g.push_back(i_tx.data);
				if (i_tx.last)
					break;
			end
			if (!i_busy && n > 4)
				break;
		end
	endtask
endmodule // mbf_master_model

/* testbench/tb_mbf_handler.sv */
`timescale 1ns/100ps
module tb_mbf_handler;
	import mbf_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_ascii = 1'b0;
	mbf_byte_type i_rx;
	logic i_tx_ready;
	mbf_dn_rsp_type i_dn = '0;
	logic [3:0] i_dn_exp_len;
	mbf_byte_type o_tx;
	mbf_dn_req_type o_dn;
	logic o_busy;
	logic o_listen;
	int bad_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int seed = 13;
	int m_listen = 0;
	int m_tmo = 2;
	int dn_err = 0;
	int dn_len = 1;
	int dn_data = 0;
	int dn_cmd = 'h1c;
	int dn_kind = 0;
	int lens[4] = '{0, 1, 2, 4};
	logic [7:0] got[$];
	int ex[$];

	mbf_handler mbf_handler_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ascii(i_ascii),
		.i_rx(i_rx), .i_tx_ready(i_tx_ready), .i_dn(i_dn), .i_dn_exp_len(i_dn_exp_len),
		.o_tx(o_tx), .o_dn(o_dn), .o_busy(o_busy), .o_listen(o_listen));
	mbf_master_model mbf_master_model_i (.i_clk(i_clk), .i_busy(o_busy), .i_tx(o_tx),
		.o_rx(i_rx), .o_tx_ready(i_tx_ready));

	// Only command 1Ch is one byte long; every other code takes two.
	assign i_dn_exp_len = (o_dn.cmd[7:0] == 8'h1c) ? 4'h1 : 4'h2;

	initial begin
		forever #5 i_clk = ~i_clk;
	end

	function automatic int rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic int hexc(int n);
		return n < 10 ? 48 + n : 55 + n;
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ------
	// Reference model
	// ------
	task automatic model(input int f[$], output int e[$]);
		int s;
		int w;
		int c;
		e = {};
		s = f.size() > 5 ? (f[2] << 8) | f[3] : 0;
		w = f.size() > 5 ? (f[4] << 8) | f[5] : 0;
		if (m_listen) begin
			if (f[1] == 8 && s == 1 && (f[4] == 0 || f[4] == 255))
				m_listen = 0;
			return;
		end
		if (f[1] == 3 && s == 0 && w == 1) begin
			e = {f[0], 3, 2, 0, m_tmo};
		end else if (f[1] == 6 && s == 0 && f[4] == 0) begin
			m_tmo = f[5];
			e = f;
		end else if (f[1] == 8 && s == 4 && w == 0) begin
			m_listen = 1;
		end else if (f[1] == 8 && (s == 0 || (s == 1 && (f[4] == 0 || f[4] == 255)))) begin
			e = f;
		end else if ((f[1] == 3 && s <= 'h17 && w == 1) || (f[1] == 6 && s > 0 && s <= 5)) begin
			// Other registers live downstream; a write is echoed once the link confirms it.
			if (dn_err)
				e = {f[0], f[1] | 128, 11};
			else if (f[1] == 6)
				e = f;
			else
				e = {f[0], 3, 2, (dn_data >> 8) & 255, dn_data & 255};
		end else if (f[1] != 3 && f[1] != 6 && f[1] != 8 && f[1] != 65) begin
			e = {f[0], f[1] | 128, 1};
		end else if (f[1] != 65 || f.size() != 2 + (f[2] == 28 ? 1 : 2)) begin
			e = {f[0], f[1] | 128, 3};
		end else if (dn_err) begin
			e = {f[0], 193, 11};
		end else begin
			e = {f[0], 65};
			for (int k = 0; k < dn_len; k++)
				e.push_back((dn_data >> (8 * k)) & 255);
		end
		if (f[0] == 0 || e.size() == 0) begin
			e = {};
			return;
		end
		c = 0;
		if (i_ascii) begin
			foreach (e[k])
				c += e[k];
			c = (0 - c) & 255;
			e.push_back(hexc(c >> 4));
			e.push_back(hexc(c & 15));
		end else begin
			c = 'hffff;
			foreach (e[k]) begin
				c ^= e[k];
				for (int i = 0; i < 8; i++)
					c = c[0] ? (c >> 1) ^ 'ha001 : c >> 1;
			end
			e.push_back(c & 255);
			e.push_back(c >> 8);
		end
	endtask

	task automatic run(input string nm, input int f[$]);
		model(f, ex);
		mbf_master_model_i.xfer(f, got);
		chk({nm, " count"}, 32'(got.size()), 32'(ex.size()));
		foreach (ex[k])
			if (k < got.size())
				chk(nm, 32'(got[k]), ex[k]);
		@(posedge i_clk);
		chk({nm, " idle"}, 32'(o_busy), 32'h0);
		$display("test %s finished", nm);
	endtask

	// ------
	// Downstream slave and watchdog
	// ------
	initial begin
		forever begin
			@(posedge i_clk);
			if (o_dn.req) begin
				chk("dn cmd", 32'(o_dn.cmd[7:0]), dn_cmd);
				chk("dn kind", 32'({o_dn.is_reg, o_dn.wr}), dn_kind);
				chk("dn len", 32'(o_dn.len), dn_kind != 0 ? 4 : 1);
				repeat (1 + (rnd() & 3)) @(posedge i_clk);
				i_dn <= '{done: 1'b1, err: dn_err[0], len: dn_len[2:0], data: dn_data};
				@(posedge i_clk);
				i_dn <= '0;
				@(posedge i_clk);
			end
		end
	end

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end

	initial begin
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		chk("tmo reset", 32'(o_dn.timeout), 32'h02);
		run("read", {8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01});
		run("write", {8'h05, 8'h06, 8'h00, 8'h00, 8'h00, 8'h1a});
		chk("tmo", 32'(o_dn.timeout), 32'h1a);
		run("bad hi", {8'h05, 8'h06, 8'h00, 8'h00, 8'h01, 8'h04});
		run("bad addr", {8'h05, 8'h06, 8'h00, 8'h06, 8'h00, 8'h00});
		run("bad sub", {8'h05, 8'h08, 8'h00, 8'h02, 8'h00, 8'h00});
		run("bad restart", {8'h05, 8'h08, 8'h00, 8'h01, 8'h12, 8'h00});
		run("restart", {8'h05, 8'h08, 8'h00, 8'h01, 8'h00, 8'h00});
		run("bad listen", {8'h05, 8'h08, 8'h00, 8'h04, 8'h00, 8'h01});
		run("listen", {8'h05, 8'h08, 8'h00, 8'h04, 8'h00, 8'h00});
		chk("offline", 32'(o_dn.offline), 32'h1);
		run("deaf", {8'h05, 8'h06, 8'h00, 8'h00, 8'h00, 8'h09});
		run("wake", {8'h05, 8'h08, 8'h00, 8'h01, 8'hff, 8'h00});
		chk("online", 32'({o_listen, o_dn.offline}), 32'h0);
		run("readback", {8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01});
		foreach (lens[k]) begin
			dn_len = lens[k];
			dn_data = rnd();
			run("pass", {8'h05, 8'h41, 8'h1c});
		end
		run("pass len", {8'h05, 8'h41, 8'h1c, 8'h00});
		run("pass long", {8'h05, 8'h41, 8'h1c, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
			8'h06, 8'h07, 8'h08});
		dn_err = 1;
		run("pass err", {8'h05, 8'h41, 8'h1c});
		dn_err = 0;
		i_ascii <= 1'b1;
		@(posedge i_clk);
		run("ascii", {8'h05, 8'h41, 8'h1c});
		run("ascii echo", {8'h05, 8'h08, 8'h00, 8'h00, 8'h5a, 8'hc3});
		i_ascii <= 1'b0;
		@(posedge i_clk);
		run("bcast", {8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h03});
		chk("bcast tmo", 32'(o_dn.timeout), 32'h03);
		dn_kind = 2;
		dn_cmd = 0;
		dn_data = rnd();
		run("dn read", {8'h05, 8'h03, 8'h00, 8'h03, 8'h00, 8'h01});
		dn_err = 1;
		run("dn err", {8'h05, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01});
		dn_err = 0;
		dn_kind = 3;
		run("dn write", {8'h05, 8'h06, 8'h00, 8'h02, 8'h12, 8'h34});
		run("bad func", {8'h05, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01});
		repeat (4)
			run("echo", {8'h05, 8'h08, 8'h00, 8'h00, rnd() & 255, rnd() & 255});
		report_and_stop();
	end
endmodule // tb_mbf_handler
